// *** rtl/cdc_pkg.sv ***
// Functional notes
// - bridge state chosen automatically, no command
// - charge, limit, slow, fast, then charge again
// - fast decay ends at charge or zero
// - forward gate patterns for charge/slow/fast
// - reverse gate patterns for charge/slow/fast
// - chop timing from oscillator ticks, except the stepper analog blank in system clocks
// - over-current ignored for four oscillator periods
// - over-current shutdown between four and five periods
// - stepper mode uses fixed analog blank
// - stepper mode forces digital blank to zero
// - digital blank only in brushed mode
// - digital blank counted in oscillator periods
// - brushed: blank after pwm/direction input change
// - brushed: blank at every charge start
// - brushed mode uses 37.5 percent mixed decay
// - brushed: first four ticks forced charge
// - over-current off until reset or standby
// - thermal shutdown off until reset or standby
`default_nettype none
package cdc_pkg;
    // register map (byte addresses)
    localparam logic [7:0] CDC_OFS_CTRL = 8'h00;
    localparam logic [7:0] CDC_OFS_STATUS = 8'h04;
    localparam logic [7:0] CDC_OFS_PERIOD = 8'h08;
    // control fields
    localparam int CDC_CTRL_EN_BIT = 0;
    localparam int CDC_CTRL_DC_BIT = 1;
    localparam int CDC_CTRL_STBY_BIT = 2;
    localparam logic [2:0] CDC_CTRL_RST = 3'h0;
    // status fields
    localparam int CDC_ST_STATE_LSB = 0;
    localparam int CDC_ST_THERM_BIT = 3;
    localparam int CDC_ST_OCP_BIT = 4;
    // chopping period in oscillator ticks
    localparam logic [7:0] CDC_PERIOD_RST = 8'h10;
    // timing counts in oscillator ticks
    localparam logic [7:0] CDC_FORCE_CHG_TICKS = 8'h04;
    localparam logic [3:0] CDC_OCP_MASK_TICKS = 4'h4;
    localparam logic [3:0] CDC_OCP_TRIP_TICKS = 4'h5;
    // fast share is 3/8 of the period
    localparam logic [1:0] CDC_FAST_NUM = 2'h3;
    localparam int CDC_FAST_SHIFT = 3;
    // analog blank in system clocks
    localparam int CDC_CLK_PS = 5000;
    localparam int CDC_BLANK_A_PS = 300000;
    localparam logic [7:0] CDC_BLANK_A_CYC = 8'((CDC_BLANK_A_PS + CDC_CLK_PS - 1) / CDC_CLK_PS);
    // gate vector order {hs1, hs2, ls1, ls2}
    localparam logic [3:0] CDC_G_FWD_CHG = 4'h9;
    localparam logic [3:0] CDC_G_REV_CHG = 4'h6;
    localparam logic [3:0] CDC_G_SLOW = 4'h3;
    localparam logic [3:0] CDC_G_FWD_FAST = 4'h6;
    localparam logic [3:0] CDC_G_REV_FAST = 4'h9;
    localparam logic [3:0] CDC_G_OFF = 4'h0;

    typedef enum logic [2:0] {
        CDC_OFF,
        CDC_CHARGE,
        CDC_SLOW,
        CDC_FAST,
        CDC_ZERO
    } cdc_state_t;
endpackage
`default_nettype wire

// *** rtl/cdc_osc_tick.sv ***
`timescale 1ns/1ps
`default_nettype none
module cdc_osc_tick
    import cdc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // oscillator level
    input wire logic osc_i,
    // one-cycle pulse per oscillator period
    output logic tick_o
);
    logic prev_q, prev_d;
    logic tick_q, tick_d;

    // rising edge of the oscillator becomes a single enable pulse
    always_comb begin
        prev_d = osc_i;
        tick_d = osc_i & ~prev_q;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            prev_q <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
            tick_q <= tick_d;
        end
    end

    assign tick_o = tick_q;
endmodule
`default_nettype wire

// *** rtl/cdc_ocp_det.sv ***
`timescale 1ns/1ps
`default_nettype none
module cdc_ocp_det
    import cdc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // oscillator enable and detector input
    input wire logic tick_i,
    input wire logic oc_i,
    input wire logic clear_i,
    // latched trip
    output logic trip_o
);
    logic [3:0] cnt_q, cnt_d;
    logic trip_q, trip_d;

    // count oscillator ticks while over-current persists
    always_comb begin
        cnt_d = cnt_q;
        trip_d = trip_q;
        if (!oc_i) begin
            cnt_d = 4'h0;
        end else if (tick_i && cnt_q < CDC_OCP_TRIP_TICKS) begin
            cnt_d = cnt_q + 4'h1;
        end
        // fifth tick: at least four full periods have passed
        if (oc_i && tick_i && cnt_q == CDC_OCP_TRIP_TICKS - 4'h1) begin
            trip_d = 1'b1;
        end
        if (clear_i) begin
            trip_d = 1'b0;
            cnt_d = 4'h0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            cnt_q <= 4'h0;
            trip_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            trip_q <= trip_d;
        end
    end

    assign trip_o = trip_q;

    ////////////////////////////////////////////////////////////////////////
    chk_ocp_mask_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (!trip_q && cnt_q < CDC_OCP_MASK_TICKS) |=> !trip_q || $past(clear_i) == 1'b0 && cnt_q != 4'h0
        && $past(cnt_q) == CDC_OCP_TRIP_TICKS - 4'h1)
        else $error("over-current trip inside mask");
    chk_ocp_trip_cause: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(trip_q) |-> $past(oc_i) && $past(tick_i) && $past(cnt_q) == CDC_OCP_TRIP_TICKS - 4'h1)
        else $error("over-current trip without persistent cause");
    cov_ocp_trip: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) $rose(trip_q));
endmodule
`default_nettype wire

// *** rtl/cdc_chopper.sv ***
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cdc_chopper
    import cdc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // motor command inputs
    input wire logic dir_i,
    input wire logic pwm_i,
    // analog feedback
    input wire logic current_limit_reached_i,
    input wire logic zero_current_i,
    input wire logic overcurrent_detect_i,
    input wire logic thermal_shutdown_i,
    input wire logic chop_oscillator_i,
    // bridge gate enables
    output logic high_side_first_o,
    output logic high_side_second_o,
    output logic low_side_first_o,
    output logic low_side_second_o,
    // protection status
    output logic fault_o
);
    // gate pattern for a bridge state and current direction
    function automatic logic [3:0] gate_pattern(cdc_state_t st, logic rev);
        case (st)
            CDC_CHARGE: gate_pattern = rev ? CDC_G_REV_CHG : CDC_G_FWD_CHG;
            CDC_SLOW, CDC_ZERO: gate_pattern = CDC_G_SLOW;
            CDC_FAST: gate_pattern = rev ? CDC_G_REV_FAST : CDC_G_FWD_FAST;
            default: gate_pattern = CDC_G_OFF;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // submodules
    logic osc_tick;
    logic ocp_trip;
    logic [2:0] ctrl_q, ctrl_d;

    cdc_osc_tick cdc_osc_tick_i (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .osc_i(chop_oscillator_i),
        .tick_o(osc_tick)
    );

    cdc_ocp_det cdc_ocp_det_i (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .tick_i(osc_tick),
        .oc_i(overcurrent_detect_i),
        .clear_i(ctrl_q[CDC_CTRL_STBY_BIT]),
        .trip_o(ocp_trip)
    );

    ////////////////////////////////////////////////////////////////////////
    // register port
    logic [7:0] period_q, period_d;
    logic [31:0] rdata_q, rdata_d;
    logic therm_q, therm_d;
    cdc_state_t state_q, state_d;

    always_comb begin
        ctrl_d = ctrl_q;
        period_d = period_q;
        rdata_d = 32'h0000_0000;
        if (reg_wr_i) begin
            case (reg_addr_i)
                CDC_OFS_CTRL: ctrl_d = reg_wdata_i[2:0];
                CDC_OFS_PERIOD: period_d = reg_wdata_i[7:0];
                default: ;
            endcase
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                CDC_OFS_CTRL: rdata_d = {29'h0, ctrl_q};
                CDC_OFS_STATUS: begin
                    rdata_d[CDC_ST_STATE_LSB +: 3] = state_q;
                    rdata_d[CDC_ST_THERM_BIT] = therm_q;
                    rdata_d[CDC_ST_OCP_BIT] = ocp_trip;
                end
                CDC_OFS_PERIOD: rdata_d = {24'h0, period_q};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ctrl_q <= CDC_CTRL_RST;
            period_q <= CDC_PERIOD_RST;
            rdata_q <= 32'h0000_0000;
        end else begin
            ctrl_q <= ctrl_d;
            period_q <= period_d;
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // protection latches
    logic fault_q, fault_d;

    always_comb begin
        therm_d = therm_q | thermal_shutdown_i;
        if (ctrl_q[CDC_CTRL_STBY_BIT]) begin
            therm_d = 1'b0;
        end
        fault_d = therm_q | ocp_trip;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            therm_q <= 1'b0;
            fault_q <= 1'b0;
        end else begin
            therm_q <= therm_d;
            fault_q <= fault_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // chopping state machine
    logic [7:0] tick_cnt_q, tick_cnt_d;
    logic [7:0] blank_q, blank_d;
    logic pwm_q, pwm_d;
    logic dir_q, dir_d;
    logic dc_mode;
    logic run;
    logic period_end;
    logic in_change;
    logic limit_ok;
    logic [9:0] fast_len;
    logic [7:0] fast_start;
    logic late;

    always_comb begin
        dc_mode = ctrl_q[CDC_CTRL_DC_BIT];
        run = ctrl_q[CDC_CTRL_EN_BIT] & ~ctrl_q[CDC_CTRL_STBY_BIT] & ~fault_q;
        period_end = osc_tick && (tick_cnt_q == period_q - 8'h01);
        in_change = (pwm_i != pwm_q) || (dir_i != dir_q);
        // fast phase takes the last 3/8 of the period in brushed mode
        fast_len = ({2'h0, period_q} * {8'h0, CDC_FAST_NUM}) >> CDC_FAST_SHIFT;
        fast_start = dc_mode ? period_q - fast_len[7:0] : period_q - (period_q >> 2);
        late = tick_cnt_q >= fast_start;
        limit_ok = current_limit_reached_i && (blank_q == 8'h00);
        state_d = state_q;
        tick_cnt_d = tick_cnt_q;
        blank_d = blank_q;
        pwm_d = pwm_i;
        dir_d = dir_i;
        // blank count: oscillator ticks in brushed mode, clocks in stepper mode
        if (blank_q != 8'h00 && (!dc_mode || osc_tick)) begin
            blank_d = blank_q - 8'h01;
        end
        if (osc_tick) begin
            tick_cnt_d = period_end ? 8'h00 : tick_cnt_q + 8'h01;
        end
        if (!run) begin
            state_d = CDC_OFF;
            tick_cnt_d = 8'h00;
            blank_d = 8'h00;
        end else if (dc_mode && !pwm_i) begin
            // brushed mode with pwm low: short brake
            state_d = CDC_SLOW;
            tick_cnt_d = 8'h00;
            blank_d = in_change ? CDC_FORCE_CHG_TICKS : blank_q;
        end else if (state_q == CDC_OFF || period_end || in_change) begin
            // every period starts in charge, ending any fast phase
            state_d = CDC_CHARGE;
            tick_cnt_d = 8'h00;
            // brushed: digital blank; stepper: analog blank only
            blank_d = dc_mode ? CDC_FORCE_CHG_TICKS : CDC_BLANK_A_CYC;
        end else begin
            case (state_q)
                CDC_CHARGE: begin
                    if (limit_ok) begin
                        state_d = late ? CDC_FAST : CDC_SLOW;
                    end
                end
                CDC_SLOW: begin
                    if (late) begin
                        state_d = CDC_FAST;
                    end
                end
                CDC_FAST: begin
                    if (zero_current_i) begin
                        state_d = CDC_ZERO;
                    end
                end
                CDC_ZERO: state_d = CDC_ZERO;
                default: state_d = CDC_OFF;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state_q <= CDC_OFF;
            tick_cnt_q <= 8'h00;
            blank_q <= 8'h00;
            pwm_q <= 1'b0;
            dir_q <= 1'b0;
        end else begin
            state_q <= state_d;
            tick_cnt_q <= tick_cnt_d;
            blank_q <= blank_d;
            pwm_q <= pwm_d;
            dir_q <= dir_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // gate drive with break-before-make
    logic [3:0] target;
    logic [3:0] gate_q, gate_d;

    always_comb begin
        target = gate_pattern(state_q, dir_q);
        // when a switch turns off, keep only common switches for one cycle before turning new ones on
        gate_d = (target == gate_q) ? gate_q : (gate_q & target);
        if (gate_d == gate_q) begin
            gate_d = target;
        end
        if (fault_q || fault_d) begin
            gate_d = CDC_G_OFF;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            gate_q <= CDC_G_OFF;
        end else begin
            gate_q <= gate_d;
        end
    end

    assign high_side_first_o = gate_q[3];
    assign high_side_second_o = gate_q[2];
    assign low_side_first_o = gate_q[1];
    assign low_side_second_o = gate_q[0];
    assign fault_o = fault_q;
    assign reg_rdata_o = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    chk_leg_no_shoot: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !(gate_q[3] && gate_q[1]) && !(gate_q[2] && gate_q[0])
        && !($past(gate_q[3]) && gate_q[1]) && !($past(gate_q[1]) && gate_q[3])
        && !($past(gate_q[2]) && gate_q[0]) && !($past(gate_q[0]) && gate_q[2]))
        else $error("high and low side of one leg overlap");
    chk_fwd_charge_gates: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_q == CDC_CHARGE && !dir_q && !fault_q && !fault_d) [*2]
        |=> gate_q == CDC_G_FWD_CHG)
        else $error("forward charge pattern wrong");
    chk_rev_fast_gates: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_q == CDC_FAST && dir_q && !fault_q && !fault_d) [*3]
        |-> gate_q == CDC_G_REV_FAST)
        else $error("reverse fast pattern wrong");
    chk_fault_gates_off: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        fault_q |-> gate_q == CDC_G_OFF)
        else $error("gates on during fault");
    chk_therm_latch_off: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (thermal_shutdown_i && !ctrl_q[CDC_CTRL_STBY_BIT]) |-> ##2 fault_q ##1 gate_q == CDC_G_OFF)
        else $error("thermal event did not shut bridge");
    chk_fast_period_end: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_q == CDC_FAST && period_end && run && !(dc_mode && !pwm_i))
        |=> state_q == CDC_CHARGE)
        else $error("fast decay outlived the period");
    chk_dc_forced_chg: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (dc_mode && state_q == CDC_CHARGE && blank_q != 8'h00 && run && pwm_i && !period_end)
        |=> state_q == CDC_CHARGE || !run)
        else $error("brushed charge left during forced ticks");
    chk_step_blank_src: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (!dc_mode && run && $changed(state_q) && state_q == CDC_CHARGE)
        |-> blank_q == CDC_BLANK_A_CYC)
        else $error("stepper charge not using analog blank");
    chk_slow_next: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_q == CDC_SLOW && run && pwm_i) |=> state_q != CDC_ZERO)
        else $error("slow decay skipped to zero point");
    cov_fast_reached: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        state_q == CDC_SLOW ##1 state_q == CDC_FAST);
    cov_direct_fast: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        state_q == CDC_CHARGE ##1 state_q == CDC_FAST);
    cov_zero_point: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        state_q == CDC_ZERO);
endmodule
`default_nettype wire

// *** dv/cdc_bridge_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module cdc_bridge_model (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // gate enables {hs1, hs2, ls1, ls2}
    input wire logic [3:0] gate_i,
    // load setup from the bench
    input wire logic [7:0] limit_i,
    input wire logic short_i,
    // sensed feedback
    output logic limit_o,
    output logic zero_o,
    output logic oc_o,
    output logic [7:0] shoot_o
);
    logic signed [9:0] cur_q;
    logic signed [9:0] cur_d;
    logic signed [9:0] mag;
    ////////////////////////////////////////////////////////////////////////////////
    // winding current: driven up or down, held in slow, freewheels to zero otherwise
    always_comb begin
        cur_d = cur_q;
        if (gate_i == 4'h9 && cur_q < 10'sh0ff) begin
            cur_d = cur_q + 10'sh001;
        end else if (gate_i == 4'h6 && cur_q > -10'sh0ff) begin
            cur_d = cur_q - 10'sh001;
        end else if (gate_i != 4'h3 && gate_i != 4'h9 && gate_i != 4'h6) begin
            cur_d = (cur_q > 0) ? cur_q - 10'sh001 : (cur_q < 0) ? cur_q + 10'sh001 : cur_q;
        end
    end
    // current register and shoot-through counter
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            cur_q <= 10'sh000;
            shoot_o <= 8'h00;
        end else begin
            cur_q <= cur_d;
            if ((gate_i[3] && gate_i[1]) || (gate_i[2] && gate_i[0])) begin
                shoot_o <= shoot_o + 8'h01;
            end
        end
    end
    // comparators: no current flows into a short while the bridge is off
    assign mag = (cur_q < 0) ? -cur_q : cur_q;
    assign limit_o = (mag >= $signed({2'b00, limit_i}));
    assign zero_o = (cur_q == 10'sh000);
    assign oc_o = short_i && (gate_i != 4'h0);
endmodule
`default_nettype wire

// *** dv/cdc_chopper_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module cdc_chopper_tb_top;
    import cdc_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0000_0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic dir_i = 1'b0;
    logic pwm_i = 1'b0;
    logic thermal_i = 1'b0;
    logic osc_i = 1'b0;
    logic lim_w, zero_w, oc_w, hs1, hs2, ls1, ls2, fault_o;
    logic [7:0] limit = 8'h01;
    logic short = 1'b0;
    logic [7:0] shoot;
    logic [3:0] gates;
    logic [31:0] rd_q;
    int n_fail = 0;
    int check_count = 0;
    int ticks = 0;
    int mark = 0;
    int osc_half = 4;
    int cycles = 0;
    ////////////////////////////////////////////////////////////////////////////////
    // clocks: reference and rc oscillator stand-in
    always #2.5 ref_clk_i = ~ref_clk_i;
    always begin
        repeat (osc_half) @(posedge ref_clk_i);
        osc_i <= ~osc_i;
    end
    always @(posedge osc_i) ticks <= ticks + 1;
    // hang guard
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_fail = n_fail + 1;
            conclude();
        end
    end
    assign gates = {hs1, hs2, ls1, ls2};
    ////////////////////////////////////////////////////////////////////////////////
    cdc_chopper cdc_chopper_i (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .dir_i(dir_i), .pwm_i(pwm_i),
        .current_limit_reached_i(lim_w), .zero_current_i(zero_w),
        .overcurrent_detect_i(oc_w), .thermal_shutdown_i(thermal_i),
        .chop_oscillator_i(osc_i), .high_side_first_o(hs1), .high_side_second_o(hs2),
        .low_side_first_o(ls1), .low_side_second_o(ls2), .fault_o(fault_o)
    );
    cdc_bridge_model cdc_bridge_model_i (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .gate_i(gates), .limit_i(limit),
        .short_i(short), .limit_o(lim_w), .zero_o(zero_w), .oc_o(oc_w), .shoot_o(shoot)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1 rd_q = reg_rdata_o;
    endtask
    // enable right after an oscillator edge so tick counts line up
    task automatic start(input logic [2:0] ctrl);
        @(posedge osc_i);
        wr(CDC_OFS_CTRL, 32'(ctrl));
        mark = ticks;
    endtask
    // half a tick past the n-th oscillator edge since mark
    task automatic at_tick(input int n);
        wait (ticks >= mark + n);
        repeat (osc_half) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic idle();
        wr(CDC_OFS_CTRL, 32'h0000_0000);
        repeat (300) @(posedge ref_clk_i);
    endtask
    task automatic conclude();
        if (n_fail == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (12) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        rd(CDC_OFS_PERIOD);
        check(rd_q, 32'(CDC_PERIOD_RST));
        @(posedge ref_clk_i);
        #1 check(reg_rdata_o, 32'h0000_0000);
        rd(8'h0c);
        check(rd_q, 32'h0000_0000);
        wr(CDC_OFS_PERIOD, 32'h0000_0020);
        rd(CDC_OFS_PERIOD);
        check(rd_q, 32'h0000_0020);
        wr(CDC_OFS_PERIOD, 32'(CDC_PERIOD_RST));
        pwm_i <= 1'b1;
        // brushed forward at two oscillator rates
        for (int k = 0; k < 2; k++) begin
            osc_half = 4 + 2 * k;
            start(3'h3);
            at_tick(3);
            check(32'(gates), 32'(CDC_G_FWD_CHG));
            at_tick(7);
            check(32'(gates), 32'(CDC_G_SLOW));
            at_tick(9);
            check(32'(gates), 32'(CDC_G_SLOW));
            at_tick(11);
            check(32'(gates), 32'(CDC_G_FWD_FAST));
            at_tick(15);
            rd(CDC_OFS_STATUS);
            check(rd_q & 32'h0000_0007, 32'h0000_0004);
            at_tick(17);
            check(32'(gates), 32'(CDC_G_FWD_CHG));
            idle();
        end
        // stepper reverse: analog blank only
        osc_half = 10;
        dir_i <= 1'b1;
        start(3'h1);
        at_tick(1);
        check(32'(gates), 32'(CDC_G_REV_CHG));
        at_tick(3);
        check(32'(gates), 32'(CDC_G_SLOW));
        at_tick(13);
        check(32'(gates), 32'(CDC_G_REV_FAST));
        idle();
        // brushed: direction change restarts charge, then short brake
        osc_half = 4;
        dir_i <= 1'b0;
        start(3'h3);
        at_tick(7);
        @(posedge ref_clk_i);
        dir_i <= 1'b1;
        mark = ticks;
        at_tick(2);
        check(32'(gates), 32'(CDC_G_REV_CHG));
        @(posedge ref_clk_i);
        pwm_i <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
        #1 check(32'(gates), 32'(CDC_G_SLOW));
        @(posedge ref_clk_i);
        pwm_i <= 1'b1;
        dir_i <= 1'b0;
        idle();
        // late limit goes straight from charge to fast
        limit <= 8'h64;
        start(3'h3);
        at_tick(11);
        check(32'(gates), 32'(CDC_G_FWD_CHG));
        at_tick(14);
        check(32'(gates), 32'(CDC_G_FWD_FAST));
        at_tick(17);
        check(32'(gates), 32'(CDC_G_FWD_CHG));
        idle();
        // over-current: short spike masked, persistent short trips
        limit <= 8'h01;
        start(3'h3);
        short <= 1'b1;
        mark = ticks;
        at_tick(2);
        @(posedge ref_clk_i);
        short <= 1'b0;
        at_tick(3);
        check(32'(fault_o), 32'h0000_0000);
        @(posedge ref_clk_i);
        short <= 1'b1;
        mark = ticks;
        at_tick(3);
        check(32'(fault_o), 32'h0000_0000);
        at_tick(7);
        check(32'({fault_o, gates}), 32'h0000_0010);
        @(posedge ref_clk_i);
        short <= 1'b0;
        repeat (40) @(posedge ref_clk_i);
        rd(CDC_OFS_STATUS);
        check(32'({fault_o, rd_q[4], gates}), 32'h0000_0030);
        wr(CDC_OFS_CTRL, 32'h0000_0004);
        wr(CDC_OFS_CTRL, 32'h0000_0003);
        repeat (4) @(posedge ref_clk_i);
        #1 check(32'({fault_o, gates}), 32'(CDC_G_FWD_CHG));
        // thermal event latches until reset
        @(posedge ref_clk_i);
        thermal_i <= 1'b1;
        @(posedge ref_clk_i);
        thermal_i <= 1'b0;
        repeat (30) @(posedge ref_clk_i);
        rd(CDC_OFS_STATUS);
        check(32'({fault_o, rd_q[3], gates}), 32'h0000_0030);
        check(32'(shoot), 32'h0000_0000);
        @(posedge ref_clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        rd(CDC_OFS_CTRL);
        check(32'({fault_o, gates, rd_q[2:0]}), 32'h0000_0000);
        conclude();
    end
endmodule
`default_nettype wire
